// file: verilog/stepper_defs.svh
// Constants for the stepper current and step-input control block.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef STEPPER_DEFS_SVH
`define STEPPER_DEFS_SVH

`define CLK_HZ 40000000
`define CLK_PERIOD_NS 25
// Idle reduction delay, in ms
`define IDLE_DELAY_MS 1000
`define IDLE_DELAY_CYCLES ((`CLK_HZ / 1000) * `IDLE_DELAY_MS)
// Current codes are in units of 0.1 A peak
`define CUR_CODE0 8'h0F
`define CUR_CODE1 8'h14
`define CUR_CODE2 8'h18
`define CUR_CODE3 8'h1C
`define CUR_CODE4 8'h20
`define CUR_CODE5 8'h25
`define CUR_CODE6 8'h2A
`define CUR_CODE7 8'h2D
`define IDLE_PCT 8'h3C
`define HALF_PCT 8'h32
`define FULL_PCT 8'h64
// AHB register byte addresses
`define ADDR_STATUS 8'h00
`define ADDR_MASK 8'h04
`define ADDR_CTRL 8'h08
`define ADDR_CURRENT 8'h0C
`define ADDR_STEPS 8'h10
// Status bit positions
`define ST_OVERVOLT 0
`define ST_OVERCUR 1
`define ST_SHORT 2
`define ST_IDLE 3
`define ST_WIDTH 4
// Control bit positions
`define CTRL_FAULT_CLR 0
`define CTRL_SW_ENABLE 1
`define CTRL_RESET_VAL 32'h0000_0002
`define CTRL_WR_MASK 32'h0000_0003
// Only whole-word writes are taken
`define HSIZE_WORD 3'h2

`endif

// file: verilog/stepper_pkg.sv
// Types shared by the stepper control files.
// Assumes nothing beyond the defs header.
package stepper_pkg;
  typedef enum logic [1:0] {
    DRV_OFF,
    DRV_RUN,
    DRV_IDLE,
    DRV_FAULT
  } drive_state_t;
endpackage : stepper_pkg

// file: verilog/stepper_idle_timer.sv
// Idle timer: counts cycles since the last accepted step edge.
// Assumes a synchronous active-low reset from the top.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defs.svh"
module stepper_idle_timer #(
  parameter int unsigned DELAY_CYCLES = `IDLE_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  output logic expired
);
  logic [31:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (restart) begin
      count <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (count >= DELAY_CYCLES - 32'h0000_0001) begin
      expired <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end
endmodule : stepper_idle_timer
`default_nettype wire

// file: verilog/stepper_ahb_slave.sv
// AHB-Lite slave front end: captures the address phase, forms strobes.
// Assumes single word transfers; always answers OKAY with no wait state.
`timescale 1ns/1ps
`default_nettype none
module stepper_ahb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic wr_en,
  output logic rd_phase,
  output logic [7:0] addr_q
);
  logic valid;

  assign valid = hsel && hready && htrans[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_en <= 1'b0;
      rd_phase <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_en <= valid && hwrite;
      rd_phase <= valid && !hwrite;
      if (valid) begin
        addr_q <= haddr[7:0];
      end
    end
  end
endmodule : stepper_ahb_slave
`default_nettype wire

// file: verilog/stepper_ctrl.sv
// Stepper driver control: current selection, idle reduction, step gating, faults.
// Assumes inputs synchronous to clk (40 MHz) and an AHB-Lite master as sole bus master.
//
// Summary of operation
// - Dynamic current code from three switches, on reads 0, first is LSB.
// - Codes 0..7 select 1.5,2.0,2.4,2.8,3.2,3.7,4.2,4.5 A peak.
// - Fourth switch on (reads 0) gives half current while running, off gives full.
// - One second after last step, current goes to 60 percent.
// - Over-voltage indication enters protection and lights the alarm output.
// - Over-current indication enters over-current protection.
// - Short between coils or to ground enters short-circuit protection.
//
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defs.svh"
module stepper_ctrl
  import stepper_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = `IDLE_DELAY_CYCLES,
  parameter int unsigned CUR_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic step_pulse_in,
  input wire logic dir_in,
  input wire logic drive_enable_in,
  input wire logic current_sel_bit0,
  input wire logic current_sel_bit1,
  input wire logic current_sel_bit2,
  input wire logic standstill_full_sel,
  input wire logic overvolt_in,
  input wire logic overcur_in,
  input wire logic short_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic alarm_led,
  output logic phase_drive_en,
  output logic [CUR_W-1:0] current_ref,
  output logic step_out,
  output logic dir_out
);
  logic rst_sync1;
  logic rst_n;
  logic step_q;
  logic step_edge;
  logic step_ok;
  logic idle_expired;
  logic wr_en;
  logic [7:0] addr_q;
  logic bus_take;
  logic size_ok;
  logic reg_wr;
  logic [31:0] next_rdata;
  logic [2:0] cur_code;
  logic [CUR_W-1:0] dyn_current;
  logic [CUR_W-1:0] next_current;
  logic [`ST_WIDTH-1:0] status;
  logic [`ST_WIDTH-1:0] mask;
  logic [`ST_WIDTH-1:0] events;
  logic [31:0] ctrl;
  logic [31:0] steps;
  logic fault_active;
  logic enabled;
  logic idle_q;
  drive_state_t state;
  drive_state_t next_state;

  // Switch on pulls low, so the code is the raw switch level
  function automatic logic [CUR_W-1:0] peak_current(input logic [2:0] code);
    case (code)
      3'h0: peak_current = CUR_W'(`CUR_CODE0);
      3'h1: peak_current = CUR_W'(`CUR_CODE1);
      3'h2: peak_current = CUR_W'(`CUR_CODE2);
      3'h3: peak_current = CUR_W'(`CUR_CODE3);
      3'h4: peak_current = CUR_W'(`CUR_CODE4);
      3'h5: peak_current = CUR_W'(`CUR_CODE5);
      3'h6: peak_current = CUR_W'(`CUR_CODE6);
      default: peak_current = CUR_W'(`CUR_CODE7);
    endcase
  endfunction : peak_current

  // Percent scaling, truncating toward zero
  function automatic logic [CUR_W-1:0] scale(input logic [CUR_W-1:0] cur,
                                             input logic [7:0] pct);
    logic [CUR_W+7:0] prod;
    prod = (CUR_W+8)'(cur) * (CUR_W+8)'(pct);
    scale = CUR_W'(prod / (CUR_W+8)'(`FULL_PCT));
  endfunction : scale

  // Write strobe for one register word
  function automatic logic word_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] where);
    word_hit = strobe && (addr == where);
  endfunction : word_hit

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  stepper_ahb_slave u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wr_en(wr_en),
    .rd_phase(),
    .addr_q(addr_q)
  );

  assign bus_take = hsel && hready && htrans[1];

  // Narrow writes are dropped rather than half applied
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      size_ok <= 1'b0;
    end else if (bus_take) begin
      size_ok <= (hsize == `HSIZE_WORD);
    end
  end

  assign reg_wr = wr_en && size_ok;

  assign cur_code = {current_sel_bit2, current_sel_bit1, current_sel_bit0};
  assign dyn_current = peak_current(cur_code);
  assign enabled = drive_enable_in && ctrl[`CTRL_SW_ENABLE];
  assign fault_active = (state == DRV_FAULT);
  assign step_edge = step_pulse_in && !step_q;
  // Step edges are dropped while faulted or disabled
  assign step_ok = step_edge && enabled && !fault_active;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 1'b0;
    end else begin
      step_q <= step_pulse_in;
    end
  end

  stepper_idle_timer #(
    .DELAY_CYCLES(IDLE_CYCLES)
  ) u_idle (
    .clk(clk),
    .rst_n(rst_n),
    .restart(step_ok || !enabled),
    .expired(idle_expired)
  );

  always_comb begin
    next_state = state;
    case (state)
      DRV_OFF: begin
        if (enabled) begin
          next_state = DRV_RUN;
        end
      end
      DRV_RUN: begin
        if (!enabled) begin
          next_state = DRV_OFF;
        end else if (idle_expired) begin
          next_state = DRV_IDLE;
        end
      end
      DRV_IDLE: begin
        if (!enabled) begin
          next_state = DRV_OFF;
        end else if (step_ok) begin
          next_state = DRV_RUN;
        end
      end
      DRV_FAULT: begin
        if (ctrl[`CTRL_FAULT_CLR] && !overvolt_in && !overcur_in && !short_in) begin
          next_state = DRV_OFF;
        end
      end
      default: next_state = DRV_OFF;
    endcase
    // Protection overrides every other state
    if (overvolt_in || overcur_in || short_in) begin
      next_state = DRV_FAULT;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DRV_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Switch-selected half or full level applies in DRV_RUN; DRV_IDLE always takes 60 percent
  always_comb begin
    next_current = '0;
    case (next_state)
      DRV_RUN: begin
        if (standstill_full_sel) begin
          next_current = dyn_current;
        end else begin
          next_current = scale(dyn_current, `HALF_PCT);
        end
      end
      DRV_IDLE: next_current = scale(dyn_current, `IDLE_PCT);
      default: next_current = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      current_ref <= '0;
      phase_drive_en <= 1'b0;
    end else begin
      current_ref <= next_current;
      phase_drive_en <= (next_state == DRV_RUN) || (next_state == DRV_IDLE);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_led <= 1'b0;
    end else begin
      alarm_led <= overvolt_in || (next_state == DRV_FAULT);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_out <= 1'b0;
      dir_out <= 1'b0;
    end else begin
      step_out <= step_ok;
      // Direction is sampled on the step edge; controller setup keeps it stable
      if (step_ok) begin
        dir_out <= dir_in;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= (next_state == DRV_IDLE);
    end
  end

  assign events[`ST_OVERVOLT] = overvolt_in;
  assign events[`ST_OVERCUR] = overcur_in;
  assign events[`ST_SHORT] = short_in;
  assign events[`ST_IDLE] = (next_state == DRV_IDLE) && !idle_q;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else if (word_hit(reg_wr, addr_q, `ADDR_STATUS)) begin
      status <= (status & ~hwdata[`ST_WIDTH-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
      ctrl <= `CTRL_RESET_VAL;
    end else if (reg_wr) begin
      if (word_hit(reg_wr, addr_q, `ADDR_MASK)) begin
        mask <= hwdata[`ST_WIDTH-1:0];
      end
      if (word_hit(reg_wr, addr_q, `ADDR_CTRL)) begin
        ctrl <= hwdata & `CTRL_WR_MASK;
      end
    end
  end

  // Counts accepted steps; pulses shorter than the minimum are the controller's fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      steps <= 32'h0000_0000;
    end else if (word_hit(reg_wr, addr_q, `ADDR_STEPS)) begin
      steps <= hwdata;
    end else if (step_ok) begin
      steps <= steps + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus_take && !hwrite) begin
      case (haddr[7:0])
        `ADDR_STATUS: next_rdata = {28'h0, status};
        `ADDR_MASK: next_rdata = {28'h0, mask};
        `ADDR_CTRL: next_rdata = ctrl;
        `ADDR_CURRENT: next_rdata = {22'h0, state, current_ref};
        `ADDR_STEPS: next_rdata = steps;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read word taken in the address phase, so the zero-wait data phase sees a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= next_rdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : stepper_ctrl
`default_nettype wire

// file: sim/stepper_ctrl_assertions.sv
// Port checker for stepper_ctrl.
// Assumes one clock domain; bound to every stepper_ctrl.
`timescale 1ns/1ps
`default_nettype none
module stepper_ctrl_checker #(
  parameter int unsigned CUR_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic step_pulse_in,
  input wire logic dir_in,
  input wire logic drive_enable_in,
  input wire logic overvolt_in,
  input wire logic overcur_in,
  input wire logic short_in,
  input wire logic alarm_led,
  input wire logic phase_drive_en,
  input wire logic [CUR_W-1:0] current_ref,
  input wire logic step_out,
  input wire logic dir_out
);
  wire logic flt = overvolt_in || overcur_in || short_in;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_step_accept: assert property (
    $rose(step_pulse_in) && drive_enable_in && phase_drive_en && !flt |=> step_out)
    else $error("step edge lost");
  a_step_single: assert property (step_out |=> !step_out)
    else $error("step_out too long");
  a_dir_capture: assert property (step_out |-> dir_out == $past(dir_in))
    else $error("dir_out not captured");
  a_fault_alarm: assert property (flt |-> ##[1:2] alarm_led)
    else $error("fault without alarm");
  a_fault_off: assert property (
    flt |-> ##2 (!phase_drive_en && current_ref == '0))
    else $error("drive on in fault");
  a_alarm_off: assert property (alarm_led |-> !phase_drive_en)
    else $error("drive on with alarm");
  a_no_step_fault: assert property ($past(alarm_led) && alarm_led |-> !step_out)
    else $error("step passed in fault");
  a_no_step_off: assert property (!$past(drive_enable_in) |-> !step_out)
    else $error("step passed when disabled");
endmodule : stepper_ctrl_checker
bind stepper_ctrl stepper_ctrl_checker #(.CUR_W(CUR_W)) u_chk (
  .clk(clk), .rstn(rstn), .step_pulse_in(step_pulse_in), .dir_in(dir_in),
  .drive_enable_in(drive_enable_in), .overvolt_in(overvolt_in),
  .overcur_in(overcur_in), .short_in(short_in), .alarm_led(alarm_led),
  .phase_drive_en(phase_drive_en), .current_ref(current_ref),
  .step_out(step_out), .dir_out(dir_out));
`default_nettype wire

// file: sim/motion_ctrl_model.sv
// Motion controller model driving enable, direction and step lines.
// Assumes a 40 MHz clock; times are in its cycles.
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_model #(
  parameter int T_SETUP = 200,
  parameter int T_PULSE = 60
) (
  input wire logic clk,
  input wire logic start,
  input wire logic en,
  input wire logic dir,
  input wire logic [7:0] n,
  output logic busy,
  output logic step_pulse_in,
  output logic dir_in,
  output logic drive_enable_in
);
  initial begin
    busy = 1'b0;
    step_pulse_in = 1'b0;
    dir_in = 1'b0;
    drive_enable_in = 1'b0;
  end
  // Full setup kept even when a level is unchanged: simpler, never too fast
  always @(posedge clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      drive_enable_in <= en;
      repeat (T_SETUP) @(posedge clk);
      dir_in <= dir;
      repeat (T_SETUP) @(posedge clk);
      for (int i = 0; i < n; i++) begin
        step_pulse_in <= 1'b1;
        repeat (T_PULSE) @(posedge clk);
        step_pulse_in <= 1'b0;
        repeat (T_PULSE) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule : motion_ctrl_model
`default_nettype wire

// file: sim/tb.sv
// Testbench for stepper_ctrl: AHB tasks plus the motion controller model.
// Assumes zero wait states and a 200 cycle idle delay.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int IDLE = 200;
  localparam logic [7:0] TAB [8] = '{8'h0F, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h25, 8'h2A, 8'h2D};
  logic clk, step_pulse_in, dir_in, drive_enable_in, busy, hreadyout, irq, alarm_led;
  logic rstn = 1'b0, start = 1'b0, en_req = 1'b0, dir_req = 1'b0, full = 1'b1;
  logic hwrite = 1'b0, phase_drive_en, step_out, dir_out, hresp;
  logic [2:0] code = 3'h0, flt = 3'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] npul = 8'h0, current_ref;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hrd_q, rd;
  int mismatches, n_checks, cyc;
  stepper_ctrl #(.IDLE_CYCLES(IDLE)) uut (
    .clk(clk), .rstn(rstn), .step_pulse_in(step_pulse_in), .dir_in(dir_in),
    .drive_enable_in(drive_enable_in), .current_sel_bit0(code[0]),
    .current_sel_bit1(code[1]), .current_sel_bit2(code[2]), .standstill_full_sel(full),
    .overvolt_in(flt[0]), .overcur_in(flt[1]), .short_in(flt[2]), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .alarm_led(alarm_led), .phase_drive_en(phase_drive_en),
    .current_ref(current_ref), .step_out(step_out), .dir_out(dir_out));
  motion_ctrl_model mc (.clk(clk), .start(start), .en(en_req), .dir(dir_req), .n(npul),
    .busy(busy), .step_pulse_in(step_pulse_in), .dir_in(dir_in),
    .drive_enable_in(drive_enable_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Read data kept as seen at the closing edge, free of update races
  always @(posedge clk) hrd_q <= hrdata;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    #1 rd = hrd_q;
  endtask : bus
  task automatic move(input logic e, input logic d, input logic [7:0] n);
    @(posedge clk);
    en_req <= e;
    dir_req <= d;
    npul <= n;
    start <= 1'b1;
    @(posedge clk);
    while (busy !== 1'b1) @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask : move
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, 32'h08, 32'h0);
    chk(rd, 32'h2);
    $display("test reset done");
    code <= 3'h7;
    bus(1'b1, 32'h10, 32'h0);
    move(1'b1, 1'b1, 8'h3);
    bus(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h3);
    chk(dir_out, 1'b1);
    for (int i = 0; i < 8; i++) begin
      code <= i[2:0];
      repeat (4) @(posedge clk);
      chk(current_ref, TAB[i]);
    end
    code <= 3'h0;
    full <= 1'b0;
    repeat (4) @(posedge clk);
    chk(current_ref, 8'h07);
    full <= 1'b1;
    bus(1'b1, 32'h04, 32'h8);
    repeat (IDLE + 10) @(posedge clk);
    chk(current_ref, 8'h09);
    bus(1'b0, 32'h0C, 32'h0);
    chk({irq, rd[9:8]}, 3'h6);
    bus(1'b1, 32'h00, 32'h8);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    move(1'b1, 1'b0, 8'h1);
    chk({dir_out, current_ref}, 9'h00F);
    $display("test current done");
    move(1'b0, 1'b0, 8'h2);
    bus(1'b0, 32'h10, 32'h0);
    chk({hresp, phase_drive_en}, 2'h0);
    chk(rd, 32'h4);
    $display("test disable done");
    for (int k = 0; k < 3; k++) begin
      move(1'b1, 1'b0, 8'h0);
      flt[k] <= 1'b1;
      @(posedge clk);
      flt[k] <= 1'b0;
      repeat (3) @(posedge clk);
      chk({alarm_led, phase_drive_en, current_ref}, 10'h200);
      bus(1'b0, 32'h00, 32'h0);
      chk(rd & 32'h7, 32'h1 << k);
      move(1'b1, 1'b0, 8'h1);
      bus(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h4);
      bus(1'b1, 32'h08, 32'h3);
      bus(1'b1, 32'h08, 32'h2);
      bus(1'b1, 32'h00, 32'hF);
      chk(alarm_led, 1'b0);
    end
    $display("test fault done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
